// file: hdl/sense_cfg.svh
// Constants of the sense switch matrix controller and its host end.
// Assumes one 20 MHz system clock shared by both ends.
`ifndef SENSE_CFG_SVH
`define SENSE_CFG_SVH

// Phase select code {phase_select_in_2, phase_select_in_1}
`define PHASE_CODE_KEEP 2'h0
`define PHASE_CODE_A 2'h1
`define PHASE_CODE_B 2'h2
`define PHASE_CODE_C 2'h3

// Output select code {output_select_in_hi, output_select_in_lo}
`define OUT_CODE_NONE 2'h0
`define OUT_CODE_A 2'h1
`define OUT_CODE_B 2'h2
`define OUT_CODE_C 2'h3

// Host register map (byte addresses)
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_COUNT 12'h008
`define CTRL_PHASE_LSB 0
`define CTRL_OUT_LSB 2
`define CTRL_RESET 4'h0

// Sample-and-hold timing
`define CLK_PERIOD_NS 50
`define SH_PERIOD_NS 20000
`define SH_TRACK_NS 1000
`define SH_PERIOD_CYC (`SH_PERIOD_NS / `CLK_PERIOD_NS)
`define SH_TRACK_CYC ((`SH_TRACK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: hdl/sense_pkg.sv
// Types shared by the sense matrix device end and its host end.
// Assumes nothing of its surroundings.
package sense_pkg;

	typedef enum logic [2:0] {
		CFG_NONE,
		CFG_1,
		CFG_2,
		CFG_3,
		CFG_4,
		CFG_5
	} sense_config_type;

	typedef enum logic [1:0] {
		PHASE_A,
		PHASE_B,
		PHASE_C
	} phase_type;

endpackage

// file: hdl/sense_link.sv
// Pin-level link between the sense matrix device and its controller.
// Assumes both ends run on the same system clock; no tristate pins.
`timescale 1ns/1ps
interface sense_link #(parameter int LEVEL_W = 12);
	logic phase_select_in_1;
	logic phase_select_in_2;
	logic output_select_in_hi;
	logic output_select_in_lo;
	logic [LEVEL_W-1:0] shared_sense_output;

	modport device (
		input phase_select_in_1,
		input phase_select_in_2,
		input output_select_in_hi,
		input output_select_in_lo,
		output shared_sense_output
	);

	modport host (
		output phase_select_in_1,
		output phase_select_in_2,
		output output_select_in_hi,
		output output_select_in_lo,
		input shared_sense_output
	);
endinterface

// file: hdl/sense_matrix_device.sv
// Switch matrix control for the back-EMF and shunt sense configurations 1 to 5.
// Assumes select pins arrive asynchronously; config bits come from logic on clk_sys.
`timescale 1ns/1ps
`include "sense_cfg.svh"

module sense_matrix_device
	import sense_pkg::*;
#(
	parameter int LEVEL_W = 12,
	parameter int SH_PERIOD = `SH_PERIOD_CYC,
	parameter int SH_TRACK = `SH_TRACK_CYC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Pins to the controller
	sense_link.device link,
	// Configuration from serial block
	input wire logic serial_mode,
	input wire logic serial_back_emf_sense_on,
	input wire logic serial_current_sense_method,
	input wire logic serial_current_sample_hold_on,
	input wire logic serial_back_emf_sample_hold_on,
	// Strap pins
	input wire logic strap_back_emf_sense_on,
	input wire logic strap_current_sense_method,
	// Center tap choice
	input wire logic center_tap_external,
	// Amplifier levels
	input wire logic [LEVEL_W-1:0] phase_a_current_amp,
	input wire logic [LEVEL_W-1:0] phase_b_current_amp,
	input wire logic [LEVEL_W-1:0] phase_c_current_amp,
	// Switch controls, bit 0 phase A, bit 1 phase B, bit 2 phase C or back-EMF
	output logic [2:0] phase_tap_closed,
	output logic center_tap_ext_closed,
	output logic center_tap_virtual_closed,
	output logic [2:0] output_mux_closed,
	output logic [2:0] sample_hold_closed,
	// Fixed routing
	output logic back_emf_chain_on,
	output logic phase_c_current_on,
	output logic select_pins_logic,
	output sense_config_type active_config
);

	localparam int PIN_N = 6;
	localparam int CNT_W = $clog2(SH_PERIOD + 1);

	// Pin input filter: three flops, change taken once stages two and three agree
	logic [PIN_N-1:0] pin_raw;
	logic [PIN_N-1:0] pin_s1_reg;
	logic [PIN_N-1:0] pin_s2_reg;
	logic [PIN_N-1:0] pin_s3_reg;
	logic [PIN_N-1:0] pin_reg;
	logic [PIN_N-1:0] pin_next;

	assign pin_raw = {strap_back_emf_sense_on, strap_current_sense_method,
		link.phase_select_in_2, link.phase_select_in_1,
		link.output_select_in_hi, link.output_select_in_lo};

	genvar gp;
	generate
		for (gp = 0; gp < PIN_N; gp++) begin : g_pin
			assign pin_next[gp] = (pin_s2_reg[gp] == pin_s3_reg[gp]) ? pin_s3_reg[gp] : pin_reg[gp];
		end
	endgenerate

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pin_s1_reg <= '0;
			pin_s2_reg <= '0;
			pin_s3_reg <= '0;
			pin_reg <= '0;
		end else begin
			pin_s1_reg <= pin_raw;
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
			pin_reg <= pin_next;
		end
	end

	wire logic strap_bemf = pin_reg[5];
	wire logic strap_method = pin_reg[4];
	wire logic [1:0] phase_code = pin_reg[3:2];
	wire logic [1:0] out_code = pin_reg[1:0];

	// Configuration decode
	wire logic eff_bemf = serial_mode ? serial_back_emf_sense_on : strap_bemf;
	wire logic eff_method = serial_mode ? serial_current_sense_method : strap_method;
	wire logic eff_cs_sh = serial_mode & serial_current_sample_hold_on;
	wire logic eff_bemf_sh = serial_mode & serial_back_emf_sample_hold_on;
	sense_config_type config_next;

	assign config_next = eff_method ? CFG_NONE :
		!eff_bemf ? (eff_cs_sh ? CFG_5 : CFG_NONE) :
		(eff_cs_sh && eff_bemf_sh) ? CFG_1 :
		eff_cs_sh ? CFG_2 :
		eff_bemf_sh ? CFG_3 : CFG_4;

	sense_config_type config_reg;
	wire logic bemf_cfg = (config_reg == CFG_1) || (config_reg == CFG_2) ||
		(config_reg == CFG_3) || (config_reg == CFG_4);
	wire logic cur_sh_cfg = (config_reg == CFG_1) || (config_reg == CFG_2) ||
		(config_reg == CFG_5);
	wire logic bemf_sh_cfg = (config_reg == CFG_1) || (config_reg == CFG_3);
	wire logic mux_cfg = (config_reg == CFG_1) || (config_reg == CFG_2) ||
		(config_reg == CFG_3) || (config_reg == CFG_5);

	// Sampled path per channel: A, B, C or back-EMF
	wire logic [2:0] path_sampled = {bemf_sh_cfg || (config_reg == CFG_5), cur_sh_cfg, cur_sh_cfg};

	// Internal sample-and-hold timing
	logic [CNT_W-1:0] sh_count_reg;
	wire logic sh_wrap = (sh_count_reg == CNT_W'(SH_PERIOD - 1));
	wire logic [CNT_W-1:0] sh_count_next = sh_wrap ? '0 : sh_count_reg + 1'b1;
	wire logic sh_track = (sh_count_reg < CNT_W'(SH_TRACK));
	wire logic [2:0] sample_hold_next = path_sampled & {3{sh_track}};

	// Phase tap decode
	phase_type phase_reg;
	phase_type phase_next;
	logic [2:0] tap_onehot;

	always_comb begin
		phase_next = phase_reg;
		unique case (phase_code)
			`PHASE_CODE_A: phase_next = PHASE_A;
			`PHASE_CODE_B: phase_next = PHASE_B;
			`PHASE_CODE_C: phase_next = PHASE_C;
			`PHASE_CODE_KEEP: phase_next = phase_reg;
		endcase
	end

	always_comb begin
		tap_onehot = 3'h0;
		unique case (phase_reg)
			PHASE_A: tap_onehot = 3'h1;
			PHASE_B: tap_onehot = 3'h2;
			PHASE_C: tap_onehot = 3'h4;
			default: tap_onehot = 3'h1;
		endcase
	end

	// Phase pins act as logic only in back-EMF configurations
	wire logic [2:0] tap_next = bemf_cfg ? tap_onehot : 3'h0;

	// Center tap choice
	wire logic ext_next = bemf_cfg & center_tap_external;
	wire logic virt_next = bemf_cfg & ~center_tap_external;

	// Output mux decode with break before make
	logic [2:0] mux_want;

	always_comb begin
		mux_want = 3'h0;
		unique case (out_code)
			`OUT_CODE_A: mux_want = 3'h1;
			`OUT_CODE_B: mux_want = 3'h2;
			`OUT_CODE_C: mux_want = 3'h4;
			`OUT_CODE_NONE: mux_want = 3'h0;
		endcase
	end

	wire logic [2:0] mux_target = mux_cfg ? mux_want : 3'h0;
	wire logic mux_break = (output_mux_closed != 3'h0) && (output_mux_closed != mux_target);
	wire logic [2:0] mux_next = mux_break ? 3'h0 : mux_target;

	// Held levels per channel
	logic [LEVEL_W-1:0] level [3];
	logic [LEVEL_W-1:0] held_reg [3];
	logic [LEVEL_W-1:0] held_next [3];

	assign level[0] = phase_a_current_amp;
	assign level[1] = phase_b_current_amp;
	assign level[2] = phase_c_current_amp;

	genvar gc;
	generate
		for (gc = 0; gc < 3; gc++) begin : g_hold
			// Sampled path follows only while its switch is closed
			assign held_next[gc] = (path_sampled[gc] && !sample_hold_closed[gc]) ?
				held_reg[gc] : level[gc];
			always_ff @(posedge clk_sys) begin
				if (reset) begin
					held_reg[gc] <= '0;
				end else begin
					held_reg[gc] <= held_next[gc];
				end
			end
		end
	endgenerate

	// Shared output buffer keeps its last value while no source is selected
	logic [LEVEL_W-1:0] shared_reg;
	wire logic [LEVEL_W-1:0] shared_next = output_mux_closed[0] ? held_reg[0] :
		output_mux_closed[1] ? held_reg[1] :
		output_mux_closed[2] ? held_reg[2] : shared_reg;

	assign link.shared_sense_output = shared_reg;

	// Control registers
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			config_reg <= CFG_NONE;
			phase_reg <= PHASE_A;
			sh_count_reg <= '0;
		end else begin
			config_reg <= config_next;
			phase_reg <= phase_next;
			sh_count_reg <= sh_count_next;
		end
	end

	// Switch registers
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			phase_tap_closed <= 3'h0;
			center_tap_ext_closed <= 1'b0;
			center_tap_virtual_closed <= 1'b0;
			output_mux_closed <= 3'h0;
			sample_hold_closed <= 3'h0;
			shared_reg <= '0;
		end else begin
			phase_tap_closed <= tap_next;
			center_tap_ext_closed <= ext_next;
			center_tap_virtual_closed <= virt_next;
			output_mux_closed <= mux_next;
			sample_hold_closed <= sample_hold_next;
			shared_reg <= shared_next;
		end
	end

	// Fixed routing registers
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			back_emf_chain_on <= 1'b0;
			phase_c_current_on <= 1'b0;
			select_pins_logic <= 1'b0;
			active_config <= CFG_NONE;
		end else begin
			back_emf_chain_on <= bemf_cfg;
			phase_c_current_on <= (config_reg == CFG_5);
			select_pins_logic <= bemf_cfg;
			active_config <= config_reg;
		end
	end

endmodule

// file: hdl/sense_matrix_host.sv
// Controller end: drives the select pins from registers reached over AHB-Lite.
// Assumes a single AHB-Lite master; shared sense output arrives asynchronously.
`timescale 1ns/1ps
`include "sense_cfg.svh"

module sense_matrix_host
	import sense_pkg::*;
#(
	parameter int LEVEL_W = 12
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Pins to the device
	sense_link.host link
);

	logic [3:0] ctrl_reg;
	logic [LEVEL_W-1:0] s1_reg;
	logic [LEVEL_W-1:0] s2_reg;
	logic [LEVEL_W-1:0] s3_reg;
	logic [LEVEL_W-1:0] level_reg;
	logic [15:0] count_reg;
	logic wr_pend_reg;
	logic [11:0] wr_addr_reg;
	logic [3:0] pins_reg;

	// Address phase decode
	wire logic addr_ok = hsel && hready && htrans[1];
	wire logic wr_take = addr_ok && hwrite && (hsize == 3'h2);
	wire logic rd_take = addr_ok && !hwrite;
	wire logic [11:0] word_addr = {haddr[11:2], 2'h0};
	wire logic [31:0] rd_value = (word_addr == `REG_CTRL) ? {28'h0, ctrl_reg} :
		(word_addr == `REG_STATUS) ? 32'(level_reg) :
		(word_addr == `REG_COUNT) ? {16'h0, count_reg} : 32'h0;
	wire logic ctrl_write = wr_pend_reg && (wr_addr_reg == `REG_CTRL);

	// Sense level accepted once stages two and three agree
	wire logic level_stable = (s2_reg == s3_reg);
	wire logic level_new = level_stable && (s3_reg != level_reg);

	// Select pins follow the control register, one cycle later
	assign {link.output_select_in_hi, link.output_select_in_lo} = pins_reg[3:2];
	assign {link.phase_select_in_2, link.phase_select_in_1} = pins_reg[1:0];

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 12'h000;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pend_reg <= wr_take;
			wr_addr_reg <= word_addr;
			hrdata <= rd_take ? rd_value : hrdata;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ctrl_reg <= `CTRL_RESET;
			pins_reg <= `CTRL_RESET;
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			level_reg <= '0;
			count_reg <= 16'h0000;
		end else begin
			ctrl_reg <= ctrl_write ? hwdata[3:0] : ctrl_reg;
			pins_reg <= ctrl_reg;
			s1_reg <= link.shared_sense_output;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			level_reg <= level_new ? s3_reg : level_reg;
			count_reg <= level_new ? count_reg + 16'h0001 : count_reg;
		end
	end

endmodule

// file: testbench/sense_switch_matrix_control_checker.sv
// Concurrent checks on the switch controls and output select pins.
// Assumes SH_TRACK of 2 cycles and the single clk_sys domain.
`timescale 1ns/1ps
module sense_switch_matrix_control_checker
	import sense_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Link pins and device side
	input wire logic output_select_in_hi,
	input wire logic output_select_in_lo,
	input wire logic center_tap_external,
	input wire logic [2:0] phase_tap_closed,
	input wire logic center_tap_ext_closed,
	input wire logic center_tap_virtual_closed,
	input wire logic [2:0] output_mux_closed,
	input wire logic [2:0] sample_hold_closed,
	input wire logic back_emf_chain_on,
	input wire logic phase_c_current_on,
	input wire logic select_pins_logic,
	input wire sense_config_type active_config
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (reset);
	wire cfg_bemf = active_config inside {CFG_1, CFG_2, CFG_3, CFG_4};
	wire cfg_5 = active_config == CFG_5;
	wire out_zero = !output_select_in_hi && !output_select_in_lo;

	a_tap_onehot: assert property ($onehot0(phase_tap_closed))
		else $error("two phase taps closed");
	a_mux_onehot: assert property ($onehot0(output_mux_closed))
		else $error("two output sources closed");
	a_mux_break: assert property (output_mux_closed != 3'h0 && $changed(output_mux_closed)
		|-> $past(output_mux_closed) == 3'h0)
		else $error("mux switched without open gap");
	a_tap_in_bemf: assert property (cfg_bemf [*3] |-> $onehot(phase_tap_closed))
		else $error("no single tap in back-emf config");
	a_center_pick: assert property ((cfg_bemf && $stable(center_tap_external)) [*3]
		|-> center_tap_ext_closed == center_tap_external
		&& center_tap_virtual_closed != center_tap_external)
		else $error("wrong center tap switch");
	a_bemf_chain: assert property (cfg_bemf [*3]
		|-> back_emf_chain_on && select_pins_logic && !phase_c_current_on)
		else $error("back-emf routing wrong");
	a_cfg4_open: assert property ((active_config == CFG_4) [*3]
		|-> output_mux_closed == 3'h0 && sample_hold_closed == 3'h0)
		else $error("switch closed in continuous config");
	a_cfg5_taps: assert property (cfg_5 [*3] |-> phase_tap_closed == 3'h0
		&& !center_tap_ext_closed && !center_tap_virtual_closed && phase_c_current_on)
		else $error("config 5 fixed switches wrong");
	// Entry into config 1 may cut a window short, so only steady config 1 counts
	a_sh_track: assert property (active_config == CFG_1 && $past(active_config) == CFG_1
		&& $rose(sample_hold_closed[0])
		|-> ##1 sample_hold_closed[0] ##1 !sample_hold_closed[0])
		else $error("track window not two cycles");
	a_cfg2_bemf_cont: assert property ((active_config == CFG_2) [*3]
		|-> !sample_hold_closed[2])
		else $error("back-emf sampled in config 2");
	a_cfg3_cur_cont: assert property ((active_config == CFG_3) [*3]
		|-> sample_hold_closed[1:0] == 2'h0)
		else $error("current sampled in config 3");
	a_code0_open: assert property (out_zero [*8] |-> output_mux_closed == 3'h0)
		else $error("mux closed with code zero");

	cover property (active_config == CFG_1 && output_mux_closed == 3'h4);
	cover property (cfg_5 && output_mux_closed == 3'h4);
	cover property ($rose(sample_hold_closed[0]));
endmodule

// file: testbench/sense_switch_matrix_control_tb.sv
// Bench joining host and device ends through sense_link.
// Assumes hdl files compile first; drives AHB-Lite and device config.
`timescale 1ns/1ps
`include "sense_cfg.svh"
module sense_switch_matrix_control_tb
	import sense_pkg::*;
	;
	logic clk_sys, reset, hsel, hwrite, hreadyout, hresp, center_tap_external;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize, phase_tap_closed, output_mux_closed, sample_hold_closed;
	logic center_tap_ext_closed, center_tap_virtual_closed;
	logic back_emf_chain_on, phase_c_current_on, select_pins_logic;
	sense_config_type active_config;
	logic [6:0] cfg_bits;
	logic [11:0] amp_lvl [1:3];
	int n_fail, samples_checked, i, o;
	// Strap pair, serial mode, serial bemf, method, cs hold, bemf hold
	logic [6:0] cv [9] = '{7'h1B, 7'h1A, 7'h19, 7'h18, 7'h12, 7'h1C, 7'h10, 7'h4B, 7'h0B};
	sense_config_type ce [9] = '{CFG_1, CFG_2, CFG_3, CFG_4, CFG_5,
		CFG_NONE, CFG_NONE, CFG_4, CFG_NONE};
	logic [6:0] oc [4] = '{7'h1B, 7'h1A, 7'h19, 7'h12};

	sense_link #(.LEVEL_W(12)) lnk();

	sense_matrix_host #(.LEVEL_W(12)) sense_matrix_host_i (.clk_sys(clk_sys), .reset(reset),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .link(lnk));

	sense_matrix_device #(.LEVEL_W(12), .SH_PERIOD(8), .SH_TRACK(2)) sense_matrix_device_i (
		.clk_sys(clk_sys), .reset(reset), .link(lnk), .serial_mode(cfg_bits[4]),
		.serial_back_emf_sense_on(cfg_bits[3]), .serial_current_sense_method(cfg_bits[2]),
		.serial_current_sample_hold_on(cfg_bits[1]),
		.serial_back_emf_sample_hold_on(cfg_bits[0]),
		.strap_back_emf_sense_on(cfg_bits[6]), .strap_current_sense_method(cfg_bits[5]),
		.center_tap_external(center_tap_external), .phase_a_current_amp(amp_lvl[1]),
		.phase_b_current_amp(amp_lvl[2]), .phase_c_current_amp(amp_lvl[3]),
		.phase_tap_closed(phase_tap_closed), .center_tap_ext_closed(center_tap_ext_closed),
		.center_tap_virtual_closed(center_tap_virtual_closed),
		.output_mux_closed(output_mux_closed), .sample_hold_closed(sample_hold_closed),
		.back_emf_chain_on(back_emf_chain_on), .phase_c_current_on(phase_c_current_on),
		.select_pins_logic(select_pins_logic), .active_config(active_config));

	sense_switch_matrix_control_checker checker_i (.clk_sys(clk_sys), .reset(reset),
		.output_select_in_hi(lnk.output_select_in_hi),
		.output_select_in_lo(lnk.output_select_in_lo),
		.center_tap_external(center_tap_external), .phase_tap_closed(phase_tap_closed),
		.center_tap_ext_closed(center_tap_ext_closed),
		.center_tap_virtual_closed(center_tap_virtual_closed),
		.output_mux_closed(output_mux_closed), .sample_hold_closed(sample_hold_closed),
		.back_emf_chain_on(back_emf_chain_on), .phase_c_current_on(phase_c_current_on),
		.select_pins_logic(select_pins_logic), .active_config(active_config));

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	// Bounded wait for hready high at a rising edge
	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			n_fail++;
			stop_test();
		end
	endtask

	task automatic ahb(input logic wr, input logic [31:0] a, wd, output logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		hsize <= 3'h2;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		d = hrdata;
	endtask

	// Pin filter plus switch register latency
	task automatic settle;
		repeat (12) @(posedge clk_sys);
	endtask

	task automatic set_cfg(input logic [6:0] v);
		cfg_bits <= v;
		settle();
	endtask

	task automatic poll_status(input logic [11:0] exp);
		logic [31:0] d;
		int n;
		n = 0;
		do begin
			ahb(1'b0, `REG_STATUS, 32'h0, d);
			n++;
		end while (d[11:0] !== exp && n < 40);
		chk("status", {20'h0, d[11:0]}, {20'h0, exp});
	endtask

	initial begin
		n_fail = 0;
		samples_checked = 0;
		reset = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		cfg_bits = 7'h0;
		center_tap_external = 1'b0;
		amp_lvl = '{12'h111, 12'h222, 12'h333};
		repeat (10) @(posedge clk_sys);
		reset <= 1'b0;
		for (i = 0; i < 9; i++) begin
			set_cfg(cv[i]);
			chk("config", active_config, ce[i]);
			if (i < 5)
				chk("fixed", {back_emf_chain_on, phase_c_current_on, select_pins_logic},
					i < 4 ? 3'h5 : 3'h2);
		end
		$display("test config done");
		set_cfg(7'h1B);
		for (i = 1; i < 5; i++) begin
			ahb(1'b1, `REG_CTRL, i % 4, rd);
			settle();
			chk("tap", phase_tap_closed, i < 4 ? 3'h1 << (i - 1) : 3'h4);
		end
		for (i = 0; i < 2; i++) begin
			center_tap_external <= i[0];
			settle();
			chk("center", {center_tap_ext_closed, center_tap_virtual_closed}, i ? 2'h2 : 2'h1);
		end
		$display("test phase done");
		for (i = 0; i < 4; i++) begin
			set_cfg(oc[i]);
			for (o = 1; o < 4; o++) begin
				ahb(1'b1, `REG_CTRL, o * 4 + 1, rd);
				settle();
				chk("mux", output_mux_closed, 3'h1 << (o - 1));
				poll_status(amp_lvl[o]);
			end
		end
		chk("cfg5 taps", {phase_tap_closed, center_tap_ext_closed, center_tap_virtual_closed}, 5'h0);
		$display("test routing done");
		set_cfg(7'h18);
		chk("cfg4", {output_mux_closed, sample_hold_closed}, 6'h0);
		set_cfg(7'h1B);
		ahb(1'b1, `REG_CTRL, 32'h5, rd);
		settle();
		chk("single shunt", output_mux_closed, 3'h1);
		poll_status(amp_lvl[1]);
		ahb(1'b1, `REG_CTRL, 32'h1, rd);
		settle();
		chk("code0", output_mux_closed, 3'h0);
		ahb(1'b0, `REG_COUNT, 32'h0, rd);
		chk("count", rd, 32'hD);
		ahb(1'b1, 32'h10, 32'hF, rd);
		ahb(1'b0, 32'h10, 32'h0, rd);
		chk("unmapped", rd, 32'h0);
		ahb(1'b0, `REG_CTRL, 32'h0, rd);
		chk("ctrl", rd, 32'h1);
		$display("test bus done");
		stop_test();
	end
endmodule
